// >>> core/scsr_cfg.svh
// register offsets, field positions and reset values of the serial channel register bank
`ifndef SCSR_CFG_SVH
`define SCSR_CFG_SVH
// write register indices
`define SCSR_WR_MODE3        4'h3
`define SCSR_WR_MODE4        4'h4
`define SCSR_WR_MODE5        4'h5
`define SCSR_WR_EXTFEAT      4'h7
`define SCSR_WR_MODE10       4'hA
`define SCSR_WR_TC_LOW       4'hC
`define SCSR_WR_TC_HIGH      4'hD
`define SCSR_WR_MISC         4'hE
`define SCSR_WR_IRQ_EN       4'hF
// read register indices
`define SCSR_RD_STATUS       4'h0
`define SCSR_RD_SPECIAL      4'h1
`define SCSR_RD_VECTOR       4'h2
`define SCSR_RD_PENDING      4'h3
`define SCSR_RD_MODE4        4'h4
`define SCSR_RD_MODE5        4'h5
`define SCSR_RD_FS_LOW       4'h6
`define SCSR_RD_FS_HIGH      4'h7
`define SCSR_RD_RXBUF        4'h8
`define SCSR_RD_MODE3        4'h9
`define SCSR_RD_MISC_STAT    4'hA
`define SCSR_RD_TC_LOW       4'hC
`define SCSR_RD_TC_HIGH      4'hD
`define SCSR_RD_MODE10       4'hE
`define SCSR_RD_IRQ_EN       4'hF
// field positions
`define SCSR_IE_ZERO_COUNT   1
`define SCSR_IE_FS_FIFO      2
`define SCSR_EF_READBACK     6
`define SCSR_ST_ZERO_COUNT   1
`define SCSR_MISC_CMD_LSB    5
`define SCSR_MISC_LOOPBACK   4
`define SCSR_MISC_ECHO       3
`define SCSR_MISC_REQ_SRC    2
`define SCSR_MISC_BRG_SRC    1
`define SCSR_MISC_BRG_EN     0
// reset values
`define SCSR_IRQ_EN_RST      8'hF0
`define SCSR_MISC_RST        8'h00
`define SCSR_MODE10_RST      8'h00
`define SCSR_VECTOR_RST      8'h00
`endif

// >>> core/scsr_pkg.sv
// types shared by the serial channel register bank
package scsr_pkg;
  typedef enum logic [2:0] {
    SCSR_CMD_NULL,
    SCSR_CMD_ENTER_SEARCH,
    SCSR_CMD_RESET_MISSING,
    SCSR_CMD_DISABLE_PLL,
    SCSR_CMD_SRC_RATE_GEN,
    SCSR_CMD_SRC_PIN,
    SCSR_CMD_SET_FM,
    SCSR_CMD_SET_NRZI
  } scsr_pll_cmd_e;
endpackage : scsr_pkg

// >>> core/scsr_pll_cmd.sv
// decoder of the phase-locked loop command field into one-cycle strobes
`timescale 1ns/100ps
module scsr_pll_cmd
  import scsr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       cmd_wr,
  input  wire logic [2:0] cmd_field,
  output logic            pll_search,
  output logic            pll_reset_missing,
  output logic            pll_disable,
  output logic            pll_src_rate_gen,
  output logic            pll_src_pin,
  output logic            pll_mode_fm,
  output logic            pll_mode_nrzi
);
  `include "scsr_cfg.svh"

  // ==========================================================
  // command decode
  scsr_pll_cmd_e cmd;
  assign cmd = scsr_pll_cmd_e'(cmd_field);

  logic [6:0] strobe_d;
  logic [6:0] strobe_q;

  // null command produces no strobe; others fire for one cycle
  always_comb begin
    strobe_d = 7'h00;
    if (cmd_wr) begin
      case (cmd)
        SCSR_CMD_NULL:          strobe_d = 7'h00;
        SCSR_CMD_ENTER_SEARCH:  strobe_d = 7'h01;
        SCSR_CMD_RESET_MISSING: strobe_d = 7'h02;
        SCSR_CMD_DISABLE_PLL:   strobe_d = 7'h04;
        SCSR_CMD_SRC_RATE_GEN:  strobe_d = 7'h08;
        SCSR_CMD_SRC_PIN:       strobe_d = 7'h10;
        SCSR_CMD_SET_FM:        strobe_d = 7'h20;
        SCSR_CMD_SET_NRZI:      strobe_d = 7'h40;
        default:                strobe_d = 7'h00;
      endcase
    end
  end

  // registered so the strobes are clean flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) strobe_q <= 7'h00;
    else        strobe_q <= strobe_d;
  end

  assign pll_search        = strobe_q[0];
  assign pll_reset_missing = strobe_q[1];
  assign pll_disable       = strobe_q[2];
  assign pll_src_rate_gen  = strobe_q[3];
  assign pll_src_pin       = strobe_q[4];
  assign pll_mode_fm       = strobe_q[5];
  assign pll_mode_nrzi     = strobe_q[6];
endmodule : scsr_pll_cmd

// >>> core/scsr_zero_irq.sv
// sticky zero-count status with enable gating for one channel
`timescale 1ns/100ps
module scsr_zero_irq (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic zero_count_evt,
  input  wire logic zero_count_en,
  input  wire logic clear,
  output logic      zero_seen,
  output logic      zero_irq
);
  // ==========================================================
  // sticky flag; a new event in the clear cycle wins
  logic seen_q;
  logic seen_d;
  assign seen_d = zero_count_evt | (seen_q & ~clear);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) seen_q <= 1'b0;
    else        seen_q <= seen_d;
  end

  assign zero_seen = seen_q;
  // the request is only raised while software enables it
  assign zero_irq  = seen_q & zero_count_en;
endmodule : scsr_zero_irq

// >>> core/scsr_regs.sv
// two-channel control and status register bank of the serial controller
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module scsr_regs
  import scsr_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             reg_chan,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic [NCH*8-1:0] rx_status,
  input  wire logic [NCH*8-1:0] special_status,
  input  wire logic [NCH*8-1:0] misc_status,
  input  wire logic [NCH*8-1:0] rx_data,
  input  wire logic [NCH*8-1:0] fs_low,
  input  wire logic [NCH*8-1:0] fs_high,
  input  wire logic [NCH*3-1:0] pending_src,
  input  wire logic [NCH-1:0]   zero_count_evt,
  input  wire logic [2:0]       vector_status,
  output logic      [NCH-1:0]   fs_pop,
  output logic      [NCH-1:0]   zero_irq,
  output logic      [NCH*16-1:0] time_constant,
  output logic      [NCH-1:0]   local_loopback,
  output logic      [NCH-1:0]   auto_echo,
  output logic      [NCH-1:0]   req_src_rate_gen,
  output logic      [NCH-1:0]   rate_gen_src_sel,
  output logic      [NCH-1:0]   rate_gen_enable,
  output logic      [NCH*7-1:0] pll_cmd_strobes,
  output logic      [NCH*8-1:0] irq_enable
);
  `include "scsr_cfg.svh"

  // ==========================================================
  // shared vector register, reachable from either channel
  logic [7:0] vector_q;
  logic [7:0] vector_d;
  wire        wr_vector = reg_wr & (reg_addr == `SCSR_RD_VECTOR);
  assign vector_d = wr_vector ? reg_wdata : vector_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) vector_q <= `SCSR_VECTOR_RST;
    else        vector_q <= vector_d;
  end

  // status-modified vector: status code replaces bits 3..1
  wire [7:0] vector_mod = {vector_q[7:4], vector_status, vector_q[0]};

  // pending bits packed B in 5..3, A in 2..0
  wire [7:0] pending_all = {2'b00, pending_src[5:3], pending_src[2:0]};

  // ==========================================================
  // per-channel register sets
  logic [7:0] chan_rdata [NCH];

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      logic [7:0] mode3_q, mode4_q, mode5_q, mode10_q;
      logic [7:0] extfeat_q, tc_low_q, tc_high_q, misc_q, ie_q;
      logic       zero_seen;
      logic [7:0] rd_mux;

      wire sel    = (reg_chan == 1'(ch));
      wire wr_sel = reg_wr & sel;
      wire rd_sel = reg_rd & sel;
      wire w3  = wr_sel & (reg_addr == `SCSR_WR_MODE3);
      wire w4  = wr_sel & (reg_addr == `SCSR_WR_MODE4);
      wire w5  = wr_sel & (reg_addr == `SCSR_WR_MODE5);
      wire w7  = wr_sel & (reg_addr == `SCSR_WR_EXTFEAT);
      wire w10 = wr_sel & (reg_addr == `SCSR_WR_MODE10);
      wire w12 = wr_sel & (reg_addr == `SCSR_WR_TC_LOW);
      wire w13 = wr_sel & (reg_addr == `SCSR_WR_TC_HIGH);
      wire w14 = wr_sel & (reg_addr == `SCSR_WR_MISC);
      wire w15 = wr_sel & (reg_addr == `SCSR_WR_IRQ_EN);

      wire readback  = extfeat_q[`SCSR_EF_READBACK];
      wire fs_enable = ie_q[`SCSR_IE_FS_FIFO];

      // plain storage; every register resets, to its defined value where there is one, else to zero
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          mode3_q   <= 8'h00;
          mode4_q   <= 8'h00;
          mode5_q   <= 8'h00;
          mode10_q  <= `SCSR_MODE10_RST;
          extfeat_q <= 8'h00;
          tc_low_q  <= 8'h00;
          tc_high_q <= 8'h00;
          misc_q    <= `SCSR_MISC_RST;
          ie_q      <= `SCSR_IRQ_EN_RST;
        end else begin
          if (w3)  mode3_q   <= reg_wdata;
          if (w4)  mode4_q   <= reg_wdata;
          if (w5)  mode5_q   <= reg_wdata;
          if (w7)  extfeat_q <= reg_wdata;
          if (w10) mode10_q  <= reg_wdata;
          if (w12) tc_low_q  <= reg_wdata;
          if (w13) tc_high_q <= reg_wdata;
          if (w14) misc_q    <= reg_wdata;
          if (w15) ie_q      <= reg_wdata;
        end
      end

      // upper byte sits in bits 15..8 of the constant
      assign time_constant[ch*16 +: 16] = {tc_high_q, tc_low_q};
      assign local_loopback[ch]   = misc_q[`SCSR_MISC_LOOPBACK];
      assign auto_echo[ch]        = misc_q[`SCSR_MISC_ECHO];
      assign req_src_rate_gen[ch] = misc_q[`SCSR_MISC_REQ_SRC];
      assign rate_gen_src_sel[ch] = misc_q[`SCSR_MISC_BRG_SRC];
      assign rate_gen_enable[ch]  = misc_q[`SCSR_MISC_BRG_EN];
      assign irq_enable[ch*8 +: 8] = ie_q;

      scsr_pll_cmd u_pll_cmd (
        .clock             (clock),
        .rst_b             (rst_b),
        .cmd_wr            (w14),
        .cmd_field         (reg_wdata[7:5]),
        .pll_search        (pll_cmd_strobes[ch*7+0]),
        .pll_reset_missing (pll_cmd_strobes[ch*7+1]),
        .pll_disable       (pll_cmd_strobes[ch*7+2]),
        .pll_src_rate_gen  (pll_cmd_strobes[ch*7+3]),
        .pll_src_pin       (pll_cmd_strobes[ch*7+4]),
        .pll_mode_fm       (pll_cmd_strobes[ch*7+5]),
        .pll_mode_nrzi     (pll_cmd_strobes[ch*7+6])
      );

      // reading the status register acknowledges the zero-count flag
      wire st_rd = rd_sel & (reg_addr == `SCSR_RD_STATUS);

      scsr_zero_irq u_zero (
        .clock          (clock),
        .rst_b          (rst_b),
        .zero_count_evt (zero_count_evt[ch]),
        .zero_count_en  (ie_q[`SCSR_IE_ZERO_COUNT]),
        .clear          (st_rd),
        .zero_seen      (zero_seen),
        .zero_irq       (zero_irq[ch])
      );

      // the fifo advances only on a legal high-byte read
      assign fs_pop[ch] = rd_sel & fs_enable & (reg_addr == `SCSR_RD_FS_HIGH);

      // read selection; channel A is index 0
      always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
          `SCSR_RD_STATUS: begin
            rd_mux = rx_status[ch*8 +: 8];
            rd_mux[`SCSR_ST_ZERO_COUNT] = zero_seen;
          end
          `SCSR_RD_SPECIAL:   rd_mux = special_status[ch*8 +: 8];
          `SCSR_RD_VECTOR:    rd_mux = (ch == 0) ? vector_q : vector_mod;
          `SCSR_RD_PENDING:   rd_mux = (ch == 0) ? pending_all : 8'h00;
          `SCSR_RD_MODE4:     rd_mux = readback ? mode4_q : 8'h00;
          `SCSR_RD_MODE5:     rd_mux = readback ? mode5_q : 8'h00;
          `SCSR_RD_FS_LOW:    rd_mux = fs_enable ? fs_low[ch*8 +: 8] : 8'h00;
          `SCSR_RD_FS_HIGH:   rd_mux = fs_enable ? fs_high[ch*8 +: 8] : 8'h00;
          `SCSR_RD_RXBUF:     rd_mux = rx_data[ch*8 +: 8];
          `SCSR_RD_MODE3:     rd_mux = readback ? mode3_q : 8'h00;
          `SCSR_RD_MISC_STAT: rd_mux = misc_status[ch*8 +: 8];
          `SCSR_RD_TC_LOW:    rd_mux = tc_low_q;
          `SCSR_RD_TC_HIGH:   rd_mux = tc_high_q;
          `SCSR_RD_MODE10:    rd_mux = readback ? mode10_q : 8'h00;
          `SCSR_RD_IRQ_EN:    rd_mux = ie_q;
          default:            rd_mux = 8'h00;
        endcase
      end
      assign chan_rdata[ch] = rd_mux;
    end
  endgenerate

  // ==========================================================
  // read data is registered and stands only the cycle after the strobe
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  assign rdata_d = reg_rd ? chan_rdata[reg_chan] : 8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rdata_q <= 8'h00;
    else        rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;
endmodule : scsr_regs

// >>> verification/scsr_regs_chk.sv
// concurrent checks on the ports of the serial channel register bank
`timescale 1ns/100ps
`include "scsr_cfg.svh"
module scsr_regs_chk #(
  parameter int NCH = 2
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              reg_chan,
  input wire logic [3:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic [NCH*8-1:0]  fs_low,
  input wire logic [NCH*3-1:0]  pending_src,
  input wire logic [NCH-1:0]    zero_count_evt,
  input wire logic [2:0]        vector_status,
  input wire logic [NCH-1:0]    fs_pop,
  input wire logic [NCH-1:0]    zero_irq,
  input wire logic [NCH*16-1:0] time_constant,
  input wire logic [NCH*7-1:0]  pll_cmd_strobes,
  input wire logic [NCH*8-1:0]  irq_enable
);
  // ====================
  // channel A accesses, plus vector and pending reads via B; one domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire rd_a = reg_rd && !reg_chan;
  wire wr_a = reg_wr && !reg_chan;
  AST_RD_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  AST_TC_HIGH:
    assert property (wr_a && reg_addr == `SCSR_WR_TC_HIGH |=> time_constant[15:8] == $past(reg_wdata))
      else $error("upper rate byte not stored");
  AST_TC_READ:
    assert property (rd_a && reg_addr == `SCSR_RD_TC_HIGH |=> reg_rdata == time_constant[15:8])
      else $error("upper rate byte read back wrong");
  AST_ZERO_GATE:
    assert property (zero_irq[0] |-> irq_enable[`SCSR_IE_ZERO_COUNT]) else $error("ungated zero irq");
  AST_ZERO_SET:
    assert property (zero_count_evt[0] && irq_enable[1] && !reg_wr |=> zero_irq[0])
      else $error("zero event lost");
  AST_VEC_B:
    assert property (reg_rd && reg_chan && reg_addr == `SCSR_RD_VECTOR
      |=> reg_rdata[3:1] == $past(vector_status)) else $error("vector status missing");
  AST_PEND_A:
    assert property (rd_a && reg_addr == `SCSR_RD_PENDING
      |=> reg_rdata == {2'b00, $past(pending_src[5:0])}) else $error("pending bits wrong");
  AST_PEND_B:
    assert property (reg_rd && reg_chan && reg_addr == `SCSR_RD_PENDING |=> reg_rdata == 8'h00)
      else $error("pending via B not zero");
  AST_FS_POP:
    assert property (fs_pop[0] |-> rd_a && irq_enable[2] && reg_addr == `SCSR_RD_FS_HIGH)
      else $error("fifo popped without enable");
  AST_FS_LOW:
    assert property (rd_a && irq_enable[2] && reg_addr == `SCSR_RD_FS_LOW
      |=> reg_rdata == $past(fs_low[7:0])) else $error("frame status low wrong");
  AST_PLL_ONE:
    assert property (wr_a && reg_addr == `SCSR_WR_MISC && reg_wdata[7:5] == 3'h1
      |=> pll_cmd_strobes[6:0] == 7'h01) else $error("search strobe wrong");
  // main scenarios reached
  cover property (fs_pop[0]);
  cover property (zero_irq[0]);
  cover property (pll_cmd_strobes[6]);
endmodule : scsr_regs_chk
bind scsr_regs scsr_regs_chk #(.NCH(NCH)) chk (.clock(clock), .rst_b(rst_b),
  .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fs_low(fs_low), .pending_src(pending_src),
  .zero_count_evt(zero_count_evt), .vector_status(vector_status), .fs_pop(fs_pop),
  .zero_irq(zero_irq), .time_constant(time_constant), .pll_cmd_strobes(pll_cmd_strobes),
  .irq_enable(irq_enable));

// >>> verification/scsr_host_model.sv
// host processor model that drives the register port
`timescale 1ns/100ps
module scsr_host_model (
  input  wire logic       clock,
  output logic            reg_chan,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ====================
  // idle bus; after a write the address and data, after a read the address, are inverted so stale values never pass
  initial begin
    reg_chan = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic ch, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_chan <= ch;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  // read data is taken only in the cycle after the strobe
  task automatic rd(input logic ch, input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_chan <= ch;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : scsr_host_model

// >>> verification/scsr_regs_test.sv
// self-checking bench of the serial channel register bank
`timescale 1ns/100ps
`include "scsr_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module scsr_regs_test;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_chan, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] rx_status = 16'h1081, special_status = 16'h005A, misc_status = 16'hC300;
  logic [15:0] rx_data = 16'h0077, fs_low = 16'h0011, fs_high = 16'h0022;
  logic [5:0]  pending_src = 6'h2D;
  logic [1:0]  zero_count_evt = 2'b00;
  logic [2:0]  vector_status = 3'b101;
  logic [1:0]  fs_pop, zero_irq, loopback, echo, req_src, src_sel, gen_en;
  logic [31:0] time_constant;
  logic [13:0] pll_cmd_strobes;
  logic [15:0] irq_enable;
  logic [3:0]  wix [4] = '{`SCSR_WR_MODE3, `SCSR_WR_MODE4, `SCSR_WR_MODE5, `SCSR_WR_MODE10};
  logic [3:0]  rix [4] = '{`SCSR_RD_MODE3, `SCSR_RD_MODE4, `SCSR_RD_MODE5, `SCSR_RD_MODE10};
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #25 clock = ~clock;
  scsr_regs uut (.clock(clock), .rst_b(rst_b), .reg_chan(reg_chan), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_status(rx_status), .special_status(special_status), .misc_status(misc_status),
    .rx_data(rx_data), .fs_low(fs_low), .fs_high(fs_high), .pending_src(pending_src),
    .zero_count_evt(zero_count_evt), .vector_status(vector_status), .fs_pop(fs_pop),
    .zero_irq(zero_irq), .time_constant(time_constant), .local_loopback(loopback),
    .auto_echo(echo), .req_src_rate_gen(req_src), .rate_gen_src_sel(src_sel),
    .rate_gen_enable(gen_en), .pll_cmd_strobes(pll_cmd_strobes), .irq_enable(irq_enable));
  scsr_host_model host (.clock(clock), .reg_chan(reg_chan), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ====================
  // shared read-and-compare
  task automatic chk_rd(input logic ch, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(ch, a, d);
    `CHK(d, exp)
  endtask : chk_rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #(50 * 3000);
    n_mismatch++;
    wrap_up();
  end
  // ====================
  // test sequence
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    `CHK(irq_enable, 16'hF0F0)
    chk_rd(0, `SCSR_RD_IRQ_EN, 8'hF0);
    $display("test reset done");
    host.wr(0, `SCSR_WR_TC_LOW, 8'h34);
    host.wr(0, `SCSR_WR_TC_HIGH, 8'h12);
    host.wr(1, `SCSR_WR_TC_HIGH, 8'hAB);
    `CHK(time_constant, 32'hAB00_1234)
    chk_rd(0, `SCSR_RD_TC_HIGH, 8'h12);
    chk_rd(1, `SCSR_RD_TC_HIGH, 8'hAB);
    chk_rd(0, `SCSR_RD_TC_LOW, 8'h34);
    $display("test rate constant done");
    for (int c = 0; c < 8; c++) begin
      host.wr(0, `SCSR_WR_MISC, {c[2:0], 5'h1F});
      `CHK(pll_cmd_strobes[6:0], (c == 0) ? 7'h00 : 7'(7'h01 << (c - 1)))
      `CHK({loopback[0], echo[0], req_src[0], src_sel[0], gen_en[0]}, 5'h1F)
      @(posedge clock);
      #1;
      `CHK(pll_cmd_strobes, 14'h0000)
    end
    $display("test loop commands done");
    host.wr(0, `SCSR_WR_IRQ_EN, 8'h00);
    @(posedge clock);
    zero_count_evt <= 2'b01;
    @(posedge clock);
    zero_count_evt <= 2'b00;
    #1;
    `CHK(zero_irq, 2'b00)
    host.wr(0, `SCSR_WR_IRQ_EN, 8'h02);
    `CHK(zero_irq, 2'b01)
    chk_rd(0, `SCSR_RD_STATUS, 8'h83);
    `CHK(zero_irq, 2'b00)
    $display("test zero count done");
    host.wr(1, 4'h2, 8'hA5);
    chk_rd(0, `SCSR_RD_VECTOR, 8'hA5);
    chk_rd(1, `SCSR_RD_VECTOR, 8'hAB);
    chk_rd(0, `SCSR_RD_PENDING, 8'h2D);
    chk_rd(1, `SCSR_RD_PENDING, 8'h00);
    $display("test vector and pending done");
    chk_rd(0, `SCSR_RD_FS_LOW, 8'h00);
    host.wr(0, `SCSR_WR_IRQ_EN, 8'h04);
    chk_rd(0, `SCSR_RD_FS_LOW, 8'h11);
    chk_rd(0, `SCSR_RD_FS_HIGH, 8'h22);
    $display("test frame status done");
    for (int i = 0; i < 4; i++) host.wr(0, wix[i], 8'h50 + i[7:0]);
    for (int i = 0; i < 4; i++) chk_rd(0, rix[i], 8'h00);
    host.wr(0, `SCSR_WR_EXTFEAT, 8'h40);
    for (int i = 0; i < 4; i++) chk_rd(0, rix[i], 8'h50 + i[7:0]);
    $display("test readback done");
    chk_rd(0, `SCSR_RD_SPECIAL, 8'h5A);
    chk_rd(1, `SCSR_RD_MISC_STAT, 8'hC3);
    chk_rd(1, `SCSR_RD_STATUS, 8'h10);
    chk_rd(0, `SCSR_RD_RXBUF, 8'h77);
    chk_rd(0, 4'hB, 8'h00);
    chk_rd(0, `SCSR_RD_IRQ_EN, 8'h04);
    $display("test status map done");
    wrap_up();
  end
endmodule : scsr_regs_test
